// ===== rtl/node_address_decoder_consts.vh
// Purpose: constants shared by the node address decoder and its divider
// Assumes: 10 MHz core clock, AXI4-Lite register access, 4-bit byte address
// Notes:   register map: control word at 0x0, status word at 0x4
//
// Overview of operation
// R01 - F8 range selects DRAM only while boot mode is off.
// R02 - F0, E and D ranges select DRAM whatever the boot mode.
// R03 - D range alone also raises the non-cacheable DRAM indication.
// R04 - non-cacheable indication drives the processor cache-enable input, disabling caching.
// R05 - top nibble 3 selects the message FIFO, end-of-data space included.
// R06 - 6 range raises local select with both encode bits: the UART.
// R07 - in boot mode F8 raises local select and encode bit 1: PROM.
// R08 - 5 range: local select, encode bit 0 (port A); 4 range: neither bit.
// R09 - selects driven only while decode enabled; expansion select when decode disabled.
// R10 - access machines sample selects only with the address strobe.
// R11 - access machines wait pending until all other piped machines are idle; localAccessStart here ignores dramBusy and cyclePending.
// R12 - three registered copies of address strobe, all cleared in reset.
// R13 - encode bits latched gated by local select; UART select when all active.
// R14 - registered local start pulse from local select and latched strobe copy.
// R15 - encode 11 UART; 10 PROM/counter; 01 counter/port A; 00 status/control.
// R16 - half-rate clock toggles each rising core edge, held low in reset.
// R17 - boot mode maps PROM over RAM and permits node counter writes.
// R18 - while DRAM busy no other access machine may start.
// R19 - cycle pending flag set when a DRAM bus transaction starts.
// R20 - a 625 kHz slow clock times the local access devices.
// R21 - only the five top address bits and boot mode affect selects; here decodeEnable gates every select too.
`ifndef NODE_ADDRESS_DECODER_CONSTS_VH
`define NODE_ADDRESS_DECODER_CONSTS_VH

// top address nibbles
`define NIB_HIGH_DRAM   4'hf
`define NIB_MID_DRAM    4'he
`define NIB_NOCACHE     4'hd
`define NIB_FIFO        4'h3
`define NIB_UART        4'h6
`define NIB_PORT_A      4'h5
`define NIB_PORT_B      4'h4

// register byte offsets
`define REG_CONTROL     4'h0
`define REG_STATUS      4'h4

// control word fields
`define CTL_BOOT        0
`define CTL_CLEAR_CYC   1
`define CTL_RESET       1'b0

// status word fields
`define ST_PENDING      0
`define ST_UART_CS      1
`define ST_LENC0        2
`define ST_LENC1        3
`define ST_DRAM_BUSY    4
`define ST_BOOT         5
`define ST_HALF_CLK     6
`define ST_SLOW_CLK     7

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// timing
`define CORE_CLK_HZ     10000000
`define SLOW_CLK_HZ     625000
`define SLOW_HALF_CYC   (`CORE_CLK_HZ / (2 * `SLOW_CLK_HZ))
`define SLOW_CNT_W      4

`endif

// ===== rtl/clock_divider.v
// Purpose: half-rate and slow timing clocks derived from the core clock
// Assumes: core_clk 10 MHz, asynchronous active-low reset
// Notes:   outputs are levels from flip-flops, not clock ports
`timescale 1ns/1ps
`default_nettype none
`include "node_address_decoder_consts.vh"

module clock_divider
(
   input  wire       core_clk,
   input  wire       reset_n,
   output reg        halfRateClock,
   output reg        slowClock
);

   // count is worked out as an integer, then cut to the counter width on purpose
   localparam integer           SLOW_LAST_I = `SLOW_HALF_CYC - 1;
   localparam [`SLOW_CNT_W-1:0] SLOW_LAST   = SLOW_LAST_I[`SLOW_CNT_W-1:0];

   reg [`SLOW_CNT_W-1:0] slowCnt_r;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         halfRateClock <= 1'b0;                    // [R16]
         slowClock     <= 1'b0;
         slowCnt_r     <= {`SLOW_CNT_W{1'b0}};
      end
      else
      begin
         halfRateClock <= ~halfRateClock;          // [R16]
         if (slowCnt_r == SLOW_LAST)
         begin
            slowCnt_r <= {`SLOW_CNT_W{1'b0}};
            slowClock <= ~slowClock;               // [R20]
         end
         else
         begin
            slowCnt_r <= slowCnt_r + 1'b1;
         end
      end
   end

endmodule // clock_divider

`default_nettype wire

// ===== rtl/node_address_decoder.v
// Purpose: top-bit address decode, strobe copies and local access start
// Assumes: all inputs synchronous to core_clk; one AXI4-Lite master
// Notes:   select pins are three-state, selOe high while they are driven
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "node_address_decoder_consts.vh"

module node_address_decoder
(
   input  wire        core_clk,
   input  wire        reset_n,
   // processor side
   input  wire [4:0]  addrTop,
   input  wire        addrStrobe,
   input  wire        decodeEnable,
   input  wire        writeNotRead,
   input  wire        dramBusy,
   // decoded selects
   output wire        selOe,
   output wire        dramSel,
   output wire        dramNoCache,
   output wire        cacheEnableIn,
   output wire        fifoSel,
   output wire        localSel,
   output wire        localEnc1,
   output wire        localEnc0,
   output wire        expSel,
   // registered local access signals
   output wire [2:0]  adsCopy,
   output reg         latchedEnc1,
   output reg         latchedEnc0,
   output reg         uartChipSel,
   output reg         localAccessStart,
   output reg         cyclePending,
   output wire        halfRateClock,
   output wire        slowClock,
   // local device strobes
   output reg         uartRead,
   output reg         uartWrite,
   output reg         promRead,
   output reg         counterRead,
   output reg         counterWrite,
   output reg         portAWrite,
   output reg         statusRead,
   output reg         controlWrite,
   // register bus
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   reg         bootMode_r;
   reg         clearCycle_r;
   reg         writeLatched_r;
   reg  [2:0]  adsCopy_r;
   reg         awHeld_r;
   reg  [3:0]  awAddr_r;
   reg         wHeld_r;
   reg  [31:0] wData_r;
   reg         wStrb0_r;

   wire [3:0]  nib;
   wire        a27;
   wire        decDram;
   wire        decNoCache;
   wire        decFifo;
   wire        decLocal;
   wire        decEnc1;
   wire        decEnc0;
   wire        pendingNxt;
   wire        startNxt;
   wire        doWrite;
   wire [31:0] statusWord;

   ////////////////////////////////////////////////////////////////////////
   // combinational decode; address bits below 27 never reach this block
   assign nib = addrTop[4:1];                                 // [R21]
   assign a27 = addrTop[0];

   assign decDram = ((nib == `NIB_HIGH_DRAM) && a27 && !bootMode_r)  // [R01]
                  || ((nib == `NIB_HIGH_DRAM) && !a27)                // [R02]
                  || (nib == `NIB_MID_DRAM)                           // [R02]
                  || (nib == `NIB_NOCACHE);                           // [R02]

   assign decNoCache = (nib == `NIB_NOCACHE);                 // [R03]

   assign decFifo = (nib == `NIB_FIFO);                       // [R05]

   // boot mode swaps the F8 window from DRAM to the boot PROM
   assign decEnc1 = (nib == `NIB_UART)                        // [R06]
                  || ((nib == `NIB_HIGH_DRAM) && a27 && bootMode_r); // [R07] [R17]

   assign decEnc0 = (nib == `NIB_UART)                        // [R06]
                  || (nib == `NIB_PORT_A);                    // [R08]

   assign decLocal = decEnc1 || decEnc0
                   || (nib == `NIB_PORT_B);                   // [R08]

   ////////////////////////////////////////////////////////////////////////
   // selects other than expSel are only driven while decode is enabled; expSel is driven while it is disabled
   assign selOe       = decodeEnable;                         // [R09]
   assign dramSel     = decodeEnable & decDram;               // [R09]
   assign dramNoCache = decodeEnable & decNoCache;            // [R09]
   assign fifoSel     = decodeEnable & decFifo;
   assign localSel    = decodeEnable & decLocal;
   assign localEnc1   = decodeEnable & decEnc1;
   assign localEnc0   = decodeEnable & decEnc0;
   assign expSel      = ~decodeEnable;                        // [R09]

   // high permits caching; the no-cache window pulls it low
   assign cacheEnableIn = ~dramNoCache;                       // [R04]

   ////////////////////////////////////////////////////////////////////////
   // three copies of the strobe keep fan-out per copy small
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_ads
         always @(posedge core_clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               adsCopy_r[gi] <= 1'b0;                         // [R12]
            end
            else
            begin
               adsCopy_r[gi] <= addrStrobe;                   // [R12]
            end
         end
      end
   endgenerate

   assign adsCopy = adsCopy_r;

   ////////////////////////////////////////////////////////////////////////
   // latched local selects and start pulse
   assign startNxt = localSel & adsCopy_r[0];                 // [R14]

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latchedEnc1      <= 1'b0;
         latchedEnc0      <= 1'b0;
         uartChipSel      <= 1'b0;
         localAccessStart <= 1'b0;
         writeLatched_r   <= 1'b0;
      end
      else
      begin
         latchedEnc1      <= localSel & localEnc1;            // [R13]
         latchedEnc0      <= localSel & localEnc0;            // [R13]
         uartChipSel      <= localSel & localEnc1 & localEnc0; // [R13]
         localAccessStart <= startNxt;                        // [R14]
         if (addrStrobe)
         begin
            writeLatched_r <= writeNotRead;                   // [R10]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // local device strobes, one cycle after the start pulse
   // counter writes are refused outside boot mode
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         uartRead     <= 1'b0;
         uartWrite    <= 1'b0;
         promRead     <= 1'b0;
         counterRead  <= 1'b0;
         counterWrite <= 1'b0;
         portAWrite   <= 1'b0;
         statusRead   <= 1'b0;
         controlWrite <= 1'b0;
      end
      else
      begin
         uartRead     <= 1'b0;
         uartWrite    <= 1'b0;
         promRead     <= 1'b0;
         counterRead  <= 1'b0;
         counterWrite <= 1'b0;
         portAWrite   <= 1'b0;
         statusRead   <= 1'b0;
         controlWrite <= 1'b0;
         if (localAccessStart)
         begin
            case ({latchedEnc1, latchedEnc0})                 // [R15]
               2'h3:
               begin
                  uartRead  <= ~writeLatched_r;
                  uartWrite <= writeLatched_r;
               end
               2'h2:
               begin
                  promRead     <= ~writeLatched_r;
                  counterWrite <= writeLatched_r & bootMode_r; // [R17]
               end
               2'h1:
               begin
                  counterRead <= ~writeLatched_r;
                  portAWrite  <= writeLatched_r;
               end
               default:
               begin
                  statusRead   <= ~writeLatched_r;
                  controlWrite <= writeLatched_r;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pending flag: a new DRAM transaction beats a clear in the same cycle
   assign pendingNxt = (addrStrobe & dramSel)                 // [R19]
                     | (cyclePending & ~clearCycle_r & ~dramBusy); // [R18]

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cyclePending <= 1'b0;
      end
      else
      begin
         cyclePending <= pendingNxt;                          // [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   clock_divider u_div
   (
      .core_clk      (core_clk),
      .reset_n       (reset_n),
      .halfRateClock (halfRateClock),
      .slowClock     (slowClock)
   );

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order
   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
   assign doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awHeld_r     <= 1'b0;
         awAddr_r     <= 4'h0;
         wHeld_r      <= 1'b0;
         wData_r      <= 32'h0;
         wStrb0_r     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         bootMode_r   <= `CTL_RESET;
         clearCycle_r <= 1'b0;
      end
      else
      begin
         clearCycle_r <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r  <= 1'b1;
            wData_r  <= s_axi_wdata;
            wStrb0_r <= s_axi_wstrb[0];
         end
         if (doWrite)
         begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_r == `REG_CONTROL)
            begin
               s_axi_bresp <= `RESP_OKAY;
               if (wStrb0_r)
               begin
                  bootMode_r   <= wData_r[`CTL_BOOT];         // [R17]
                  clearCycle_r <= wData_r[`CTL_CLEAR_CYC];
               end
            end
            else if (awAddr_r == `REG_STATUS)
            begin
               s_axi_bresp <= `RESP_OKAY;
            end
            else
            begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel
   assign s_axi_arready = ~s_axi_rvalid;

   assign statusWord = {24'h0,
                        slowClock,
                        halfRateClock,
                        bootMode_r,
                        dramBusy,
                        latchedEnc1,
                        latchedEnc0,
                        uartChipSel,
                        cyclePending};

   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr == `REG_CONTROL)
            begin
               s_axi_rdata <= {31'h0, bootMode_r};
               s_axi_rresp <= `RESP_OKAY;
            end
            else if (s_axi_araddr == `REG_STATUS)
            begin
               s_axi_rdata <= statusWord;
               s_axi_rresp <= `RESP_OKAY;
            end
            else
            begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // node_address_decoder

`default_nettype wire

// ===== bench/node_address_decoder_sva.sv
// Purpose: port checks for the node address decoder
// Assumes: one clock, asynchronous active-low reset
// Notes:   boot mode is internal, so its ranges are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module node_address_decoder_sva
(
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic [4:0] addrTop,
   input wire logic       addrStrobe,
   input wire logic       decodeEnable,
   input wire logic       selOe,
   input wire logic       dramSel,
   input wire logic       dramNoCache,
   input wire logic       cacheEnableIn,
   input wire logic       fifoSel,
   input wire logic       localSel,
   input wire logic       localEnc1,
   input wire logic       localEnc0,
   input wire logic       expSel,
   input wire logic [2:0] adsCopy,
   input wire logic       latchedEnc1,
   input wire logic       latchedEnc0,
   input wire logic       uartChipSel,
   input wire logic       localAccessStart,
   input wire logic       cyclePending,
   input wire logic       halfRateClock
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic [3:0] nib = addrTop[4:1];
   wire logic       uartCause = localSel & localEnc1 & localEnc0;
   wire logic       enc1Cause = localSel & localEnc1;
   wire logic       startCause = localSel & adsCopy[0];
   ////////////////////////////////////////////////////////////
   exp_sel_a: assert property (expSel == !decodeEnable && selOe == decodeEnable)
      else $error("expansion select wrong");
   no_cache_a: assert property (dramNoCache == (decodeEnable && nib == 4'hd)
      && cacheEnableIn == !dramNoCache) else $error("no-cache decode wrong");
   dram_range_a: assert property (decodeEnable && (nib == 4'he || nib == 4'hd
      || addrTop == 5'h1e) |-> dramSel) else $error("dram range missed");
   fifo_range_a: assert property (fifoSel == (decodeEnable && nib == 4'h3))
      else $error("fifo decode wrong");
   uart_range_a: assert property (decodeEnable && nib == 4'h6 |->
      localSel && localEnc1 && localEnc0 && !dramSel) else $error("uart decode wrong");
   port_range_a: assert property (decodeEnable && (nib == 4'h5 || nib == 4'h4) |->
      localSel && !localEnc1 && localEnc0 == nib[0]) else $error("port decode wrong");
   strobe_copy_a: assert property ($past(reset_n) |-> adsCopy == {3{$past(addrStrobe)}})
      else $error("strobe copies wrong");
   uart_cs_a: assert property ($past(reset_n) |-> uartChipSel == $past(uartCause)
      && latchedEnc1 == $past(enc1Cause) && latchedEnc0 == $past(localSel & localEnc0))
      else $error("latched local select wrong");
   start_pulse_a: assert property ($past(reset_n) |->
      localAccessStart == $past(startCause)) else $error("local start wrong");
   half_clock_a: assert property ($past(reset_n) |->
      halfRateClock != $past(halfRateClock)) else $error("half rate clock stuck");
   pend_set_a: assert property (addrStrobe && dramSel |=> cyclePending)
      else $error("pending not set");
   dram_cov: cover property (addrStrobe && dramSel);
   start_cov: cover property (localAccessStart && uartChipSel);
   clear_cov: cover property ($rose(cyclePending) ##[1:20] !cyclePending);
endmodule // node_address_decoder_sva
bind node_address_decoder node_address_decoder_sva chk_u (.core_clk(core_clk),
   .reset_n(reset_n), .addrTop(addrTop), .addrStrobe(addrStrobe),
   .decodeEnable(decodeEnable), .selOe(selOe), .dramSel(dramSel),
   .dramNoCache(dramNoCache), .cacheEnableIn(cacheEnableIn), .fifoSel(fifoSel),
   .localSel(localSel), .localEnc1(localEnc1), .localEnc0(localEnc0), .expSel(expSel),
   .adsCopy(adsCopy), .latchedEnc1(latchedEnc1), .uartChipSel(uartChipSel),
   .localAccessStart(localAccessStart), .cyclePending(cyclePending),
   .halfRateClock(halfRateClock), .latchedEnc0(latchedEnc0));
`default_nettype wire

// ===== bench/dram_ctrl_model.sv
// Purpose: far-side dram controller answering the pending flag
// Assumes: waitCycles sets how slowly it takes a pending cycle
// Notes:   busy always lasts three cycles
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       cyclePending,
   input  wire logic [3:0] waitCycles,
   output var  logic       dramBusy
);
   logic [3:0] cnt_r;
   // starts only from a pending cycle, then busy holds others off
   always @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         {dramBusy, cnt_r} <= 5'h00;
      else if (dramBusy)
         {dramBusy, cnt_r} <= (cnt_r == 4'h2) ? 5'h00 : {1'b1, cnt_r + 4'h1};
      else if (!cyclePending)
         cnt_r <= 4'h0; // a cleared request is dropped, not served
      else if (cnt_r >= waitCycles)
         {dramBusy, cnt_r} <= 5'h10;
      else
         cnt_r <= cnt_r + 4'h1;
   end
endmodule // dram_ctrl_model
`default_nettype wire

// ===== bench/test_node_address_decoder.sv
// Purpose: self-checking bench for the node address decoder
// Assumes: 10 MHz core clock, register access over AXI4-Lite
// Notes:   decode model below is the reference for every select
`timescale 1ns/1ps
`default_nettype none
`include "node_address_decoder_consts.vh"
module test_node_address_decoder;
   logic        core_clk = 1'b0, reset_n = 1'b0, addrStrobe = 1'b0;
   logic        decodeEnable = 1'b0, writeNotRead = 1'b0;
   logic [4:0]  addrTop = 5'h00;
   logic [3:0]  waitCycles = 4'h1, awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, d, seed = 32'h4fdc; // xorshift start 20444
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, w;
   wire  [8:0]  sels;
   wire  [7:0]  stb;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         dramBusy, awready, wready, bvalid, arready, rvalid, cyclePending, slowClock;
   int          fails = 0, n_checks = 0, i, j, b;
   logic [4:0]  locAddr [4] = '{5'h08, 5'h0a, 5'h1f, 5'h0c};
   logic [7:0]  stbTab [8] = '{8'h02, 8'h01, 8'h10, 8'h04, 8'h20, 8'h08, 8'h80, 8'h40};
   always #50 core_clk = ~core_clk;
   node_address_decoder dut_u (.core_clk(core_clk), .reset_n(reset_n), .addrTop(addrTop),
      .addrStrobe(addrStrobe), .decodeEnable(decodeEnable), .writeNotRead(writeNotRead),
      .dramBusy(dramBusy), .selOe(sels[0]), .dramSel(sels[8]), .dramNoCache(sels[7]),
      .cacheEnableIn(sels[6]), .fifoSel(sels[5]), .localSel(sels[4]), .localEnc1(sels[3]),
      .localEnc0(sels[2]), .expSel(sels[1]), .adsCopy(), .latchedEnc1(), .latchedEnc0(),
      .uartChipSel(), .localAccessStart(), .cyclePending(cyclePending),
      .halfRateClock(), .slowClock(slowClock), .uartRead(stb[7]), .uartWrite(stb[6]),
      .promRead(stb[5]), .counterRead(stb[4]), .counterWrite(stb[3]), .portAWrite(stb[2]),
      .statusRead(stb[1]), .controlWrite(stb[0]), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   dram_ctrl_model drm_u (.core_clk(core_clk), .reset_n(reset_n),
      .cyclePending(cyclePending), .waitCycles(waitCycles), .dramBusy(dramBusy));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // reference decode: {dram, nocache, cacheEn, fifo, local, enc1, enc0, exp, oe}
   function automatic logic [8:0] dec(input logic [4:0] a, input logic bt, input logic de);
      logic [3:0] n;
      logic       f8, nc, l1;
      begin
         n = a[4:1];
         f8 = (a == 5'h1f);
         nc = de && n == 4'hd;
         l1 = n == 4'h6 || f8 && bt;
         dec = {de && (f8 && !bt || a == 5'h1e || n == 4'he || n == 4'hd), nc, !nc,
            de && n == 4'h3, de && (l1 || n == 4'h5 || n == 4'h4), de && l1,
            de && (n == 4'h6 || n == 4'h5), !de, de};
      end
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] expv);
      begin
         n_checks++;
         if (got !== expv)
         begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv);
         end
      end
   endtask
   task automatic close_out;
      begin
         $display("checks=%0d fails=%0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task automatic hang;
      begin
         check(32'h0, 32'h1); // a wait ran out
         close_out();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] dt, input logic [1:0] er);
      int k;
      begin
         @(posedge core_clk);
         awaddr <= a;
         wdata <= dt;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         for (k = 0; k < 40 && bvalid !== 1'b1; k++)
         begin
            @(posedge core_clk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
         end
         bready <= 1'b0;
         if (k == 40)
            hang();
         check({30'h0, bresp}, {30'h0, er});
      end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] dt, input logic [1:0] er);
      int k;
      begin
         @(posedge core_clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         for (k = 0; k < 40 && rvalid !== 1'b1; k++)
         begin
            @(posedge core_clk);
            if (arready)
               arvalid <= 1'b0;
         end
         rready <= 1'b0;
         dt = rdata;
         if (k == 40)
            hang();
         check({30'h0, rresp}, {30'h0, er});
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      for (b = 0; b < 2; b++)
      begin
         wr(4'h0, {31'h0, b[0]}, 2'h0);
         rd(4'h4, d, 2'h0);
         check({31'h0, d[5]}, {31'h0, b[0]});
         for (i = 0; i < 40; i++)
         begin
            seed = xs(seed);
            @(posedge core_clk);
            addrTop <= (i < 2) ? 5'h1f : seed[4:0];
            decodeEnable <= seed[7:5] != 3'h0;
            @(negedge core_clk);
            check({23'h0, sels}, {23'h0, dec(addrTop, b[0], decodeEnable)});
         end
      end
      wr(4'h8, 32'h0, 2'h2); // unmapped places answer with an error
      rd(4'hc, d, 2'h2);
      check(d, 32'h0);
      // boot still on, so F8 reaches the prom encode
      for (i = 0; i < 8; i++)
      begin
         @(posedge core_clk);
         addrTop <= locAddr[i / 2];
         decodeEnable <= 1'b1;
         writeNotRead <= i[0];
         addrStrobe <= 1'b1;
         @(posedge core_clk);
         addrStrobe <= 1'b0;
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         check({24'h0, stb}, {24'h0, stbTab[i]});
      end
      wr(4'h0, 32'h0, 2'h0);
      for (b = 0; b < 2; b++)
      begin
         // slow partner leaves time for the software clear
         waitCycles <= b[0] ? 4'hf : 4'h1;
         @(posedge core_clk);
         addrTop <= 5'h1f;
         addrStrobe <= 1'b1;
         @(posedge core_clk);
         addrStrobe <= 1'b0;
         @(negedge core_clk);
         check({31'h0, cyclePending}, 32'h1);
         if (b == 1)
         begin
            rd(4'h4, d, 2'h0);
            check({31'h0, d[0]}, 32'h1);
            wr(4'h0, 32'h2, 2'h0);
            rd(4'h4, d, 2'h0);
            check({31'h0, d[0]}, 32'h0);
         end
         for (i = 0; i < 20 && cyclePending !== 1'b0; i++)
            @(posedge core_clk);
         if (i == 20)
            hang();
      end
      w = slowClock;
      for (i = 0; i < 20 && slowClock === w; i++)
         @(posedge core_clk);
      w = slowClock;
      for (j = 0; j < 20 && slowClock === w; j++)
         @(posedge core_clk);
      check(j, `SLOW_HALF_CYC);
      close_out();
   end
endmodule // test_node_address_decoder
`default_nettype wire
